// ==== hw/plm_pkg.sv ====
// Package for the link-mode resolution block: register map, fields, types and timing.
// Assumes a 10 MHz core clock and a plain one-cycle register port.
package plm_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned RESTART_TIME_MS = 1200;
  localparam int unsigned RESTART_CYC     = RESTART_TIME_MS * (CLK_HZ / 1000);

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_LPA  = 4'h8;
  localparam logic [3:0] ADDR_ADV  = 4'hC;

  localparam int CTRL_MS_VAL  = 0;
  localparam int CTRL_MS_EN   = 1;
  localparam int CTRL_SPD_HI  = 6;
  localparam int CTRL_DUPLEX  = 8;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_AN_EN   = 12;
  localparam int CTRL_SPD_LO  = 13;
  localparam int CTRL_SW_RST  = 15;

  localparam logic [15:0] CTRL_RST = 16'h1000;
  localparam logic [15:0] ADV_RST  = 16'h001F;
  localparam logic [15:0] LPA_10H  = 16'h0001;
  localparam logic [15:0] LPA_100H = 16'h0004;

  localparam int ABL_10H   = 0;
  localparam int ABL_10F   = 1;
  localparam int ABL_100H  = 2;
  localparam int ABL_100F  = 3;
  localparam int ABL_1000F = 4;

  typedef enum logic [1:0] {
    SPD_10   = 2'h0,
    SPD_100  = 2'h1,
    SPD_1000 = 2'h2
  } plm_speed_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_NEG   = 3'h1,
    ST_MS    = 3'h3,
    ST_LINK  = 3'h2,
    ST_FAULT = 3'h6,
    ST_FORCE = 3'h4
  } plm_state_t;

  typedef enum logic [1:0] {
    MS_MASTER = 2'h0,
    MS_SLAVE  = 2'h1,
    MS_FAULT  = 2'h2,
    MS_TIE    = 2'h3
  } plm_ms_t;

  typedef struct packed {
    logic        manual;
    logic        value;
    logic        multiport;
    logic [10:0] seed;
  } plm_ms_cfg_t;

  typedef struct packed {
    logic flp;
    logic mlt3;
    logic nlp;
    logic lost;
  } plm_line_t;

endpackage

// ==== hw/plm_top.sv ====
// Link-mode resolution: parallel detection, gigabit master/slave, forced mode and carrier sense.
// Assumes line indications are already qualified and synchronous to clk_i.
`timescale 1ns/1ps

module plm_top #(
  parameter int unsigned RESTART_CYCLES = plm_pkg::RESTART_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [15:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [15:0]          reg_rdata_o,
  input  wire plm_pkg::plm_line_t   line_i,
  input  wire logic                 lp_code_valid_i,
  input  wire logic [15:0]          lp_code_i,
  input  wire plm_pkg::plm_ms_cfg_t lp_ms_i,
  input  wire logic [10:0]          local_seed_i,
  input  wire logic                 cfg_an_en_i,
  input  wire logic                 cfg_ms_manual_i,
  input  wire logic                 cfg_master_i,
  input  wire logic                 cfg_multiport_i,
  input  wire logic                 pdn_reset_i,
  input  wire logic                 tx_active_i,
  input  wire logic                 rx_active_i,
  output logic                      link_up_o,
  output plm_pkg::plm_speed_t       speed_o,
  output logic                      full_duplex_o,
  output logic                      master_o,
  output logic                      tx_recovered_clk_o,
  output logic                      crs_o,
  output logic                      col_o
);

  // Resolves the gigabit role from both sides' configurations.
  function automatic plm_pkg::plm_ms_t ms_resolve(input plm_pkg::plm_ms_cfg_t loc,
                                                  input plm_pkg::plm_ms_cfg_t rem);
    plm_pkg::plm_ms_t r;
    r = plm_pkg::MS_TIE;
    if (loc.manual && rem.manual && (loc.value == rem.value)) begin
      r = plm_pkg::MS_FAULT;
    end else if (loc.manual) begin
      r = loc.value ? plm_pkg::MS_MASTER : plm_pkg::MS_SLAVE;
    end else if (rem.manual) begin
      r = rem.value ? plm_pkg::MS_SLAVE : plm_pkg::MS_MASTER;
    end else if (loc.multiport != rem.multiport) begin
      r = loc.multiport ? plm_pkg::MS_MASTER : plm_pkg::MS_SLAVE;
    end else if (loc.seed > rem.seed) begin
      r = plm_pkg::MS_MASTER;
    end else if (loc.seed < rem.seed) begin
      r = plm_pkg::MS_SLAVE;
    end
    return r;
  endfunction

  // Picks the highest common ability: {valid, speed, full}.
  function automatic logic [3:0] hcd(input logic [4:0] c);
    logic [3:0] r;
    r = 4'h0;
    if (c[plm_pkg::ABL_1000F]) begin
      r = {1'b1, plm_pkg::SPD_1000, 1'b1};
    end else if (c[plm_pkg::ABL_100F]) begin
      r = {1'b1, plm_pkg::SPD_100, 1'b1};
    end else if (c[plm_pkg::ABL_100H]) begin
      r = {1'b1, plm_pkg::SPD_100, 1'b0};
    end else if (c[plm_pkg::ABL_10F]) begin
      r = {1'b1, plm_pkg::SPD_10, 1'b1};
    end else if (c[plm_pkg::ABL_10H]) begin
      r = {1'b1, plm_pkg::SPD_10, 1'b0};
    end
    return r;
  endfunction

  plm_pkg::plm_state_t  state_q;
  plm_pkg::plm_state_t  state_d;
  logic [23:0]          wait_q;
  logic [15:0]          ctrl_q;
  logic [15:0]          adv_q;
  logic [15:0]          lpa_q;
  logic [15:0]          rdata_q;
  logic                 link_q;
  plm_pkg::plm_speed_t  speed_q;
  logic                 full_q;
  logic                 master_q;
  logic                 lp_an_able_q;
  logic                 pd_fault_q;
  logic                 ms_fault_q;
  logic                 an_done_q;
  logic                 crs_q;
  logic                 col_q;
  logic                 txclk_q;

  logic                 an_en_eff;
  logic                 ctrl_wr;
  logic                 restart_req;
  logic                 sw_rst;
  logic                 stat_rd;
  logic                 code_rx;
  logic [3:0]           hcd_res;
  logic                 go_link_an;
  logic                 go_link_pd;
  logic                 pd_fault_ev;
  logic                 ms_ok;
  logic                 ms_fault_ev;
  logic                 ms_tweak;
  plm_pkg::plm_ms_cfg_t local_ms;
  plm_pkg::plm_ms_t     ms_res;
  plm_pkg::plm_speed_t  force_spd;
  logic                 force_ok;

  assign ctrl_wr     = reg_wr_i && (reg_addr_i == plm_pkg::ADDR_CTRL);
  assign restart_req = ctrl_wr && reg_wdata_i[plm_pkg::CTRL_RESTART];
  assign sw_rst      = ctrl_wr && reg_wdata_i[plm_pkg::CTRL_SW_RST];
  assign stat_rd     = reg_rd_i && (reg_addr_i == plm_pkg::ADDR_STAT);
  assign an_en_eff   = ctrl_q[plm_pkg::CTRL_AN_EN] && cfg_an_en_i;
  assign code_rx     = (state_q == plm_pkg::ST_NEG) && line_i.flp && lp_code_valid_i;
  assign hcd_res     = hcd(adv_q[4:0] & lp_code_i[4:0]);
  assign go_link_an  = code_rx && hcd_res[3] && (hcd_res[2:1] != plm_pkg::SPD_1000);
  assign go_link_pd  = (state_q == plm_pkg::ST_NEG) && !line_i.flp && (line_i.mlt3 ^ line_i.nlp);
  assign pd_fault_ev = (state_q == plm_pkg::ST_NEG) && !line_i.flp && line_i.mlt3 && line_i.nlp;
  assign local_ms = '{manual:    ctrl_q[plm_pkg::CTRL_MS_EN] | cfg_ms_manual_i,
                      value:     ctrl_q[plm_pkg::CTRL_MS_EN] ? ctrl_q[plm_pkg::CTRL_MS_VAL]
                                                             : cfg_master_i,
                      multiport: cfg_multiport_i,
                      seed:      local_seed_i};
  assign ms_res      = ms_resolve(local_ms, lp_ms_i);
  assign ms_ok       = (state_q == plm_pkg::ST_MS) &&
                       ((ms_res == plm_pkg::MS_MASTER) || (ms_res == plm_pkg::MS_SLAVE));
  assign ms_fault_ev = (state_q == plm_pkg::ST_MS) && (ms_res == plm_pkg::MS_FAULT);
  assign ms_tweak    = ctrl_wr && (reg_wdata_i[1:0] != ctrl_q[1:0]);
  assign force_spd   = plm_pkg::plm_speed_t'({ctrl_q[plm_pkg::CTRL_SPD_HI],
                                              ctrl_q[plm_pkg::CTRL_SPD_LO]});
  assign force_ok    = ((force_spd == plm_pkg::SPD_100) && line_i.mlt3) ||
                       ((force_spd == plm_pkg::SPD_10) && line_i.nlp);

  always_comb begin
    state_d = state_q;
    case (state_q)
      plm_pkg::ST_IDLE: begin
        if (wait_q == 24'h0) begin
          state_d = an_en_eff ? plm_pkg::ST_NEG : plm_pkg::ST_FORCE;
        end
      end
      plm_pkg::ST_NEG: begin
        if (!an_en_eff) begin
          state_d = plm_pkg::ST_IDLE;
        end else if (code_rx && hcd_res[3]) begin
          state_d = go_link_an ? plm_pkg::ST_LINK : plm_pkg::ST_MS;
        end else if (go_link_pd) begin
          state_d = plm_pkg::ST_LINK;
        end
      end
      plm_pkg::ST_MS: begin
        if (ms_ok) begin
          state_d = plm_pkg::ST_LINK;
        end else if (ms_fault_ev) begin
          state_d = plm_pkg::ST_FAULT;
        end else begin
          state_d = plm_pkg::ST_NEG;
        end
      end
      plm_pkg::ST_LINK: begin
        if (line_i.lost || !an_en_eff) begin
          state_d = plm_pkg::ST_IDLE;
        end
      end
      plm_pkg::ST_FORCE: begin
        if (an_en_eff) begin
          state_d = plm_pkg::ST_IDLE;
        end
      end
      plm_pkg::ST_FAULT: begin
        if ((wait_q == 24'h0) || ms_tweak) begin
          state_d = plm_pkg::ST_IDLE;
        end
      end
      default: state_d = plm_pkg::ST_IDLE;
    endcase
    if (sw_rst || pdn_reset_i || restart_req) begin
      state_d = plm_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= plm_pkg::ST_IDLE;
      wait_q  <= 24'h0;
    end else begin
      state_q <= state_d;
      if (restart_req && !sw_rst && !pdn_reset_i) begin
        wait_q <= RESTART_CYCLES[23:0];
      end else if (sw_rst || pdn_reset_i) begin
        wait_q <= 24'h0;
      end else if (ms_fault_ev) begin
        wait_q <= RESTART_CYCLES[23:0];
      end else if ((wait_q != 24'h0) && (state_q != plm_pkg::ST_FAULT || !ms_tweak)) begin
        wait_q <= wait_q - 24'h1;
      end else begin
        wait_q <= 24'h0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= plm_pkg::CTRL_RST;
      adv_q  <= plm_pkg::ADV_RST;
    end else if (sw_rst) begin
      ctrl_q <= plm_pkg::CTRL_RST;
      adv_q  <= plm_pkg::ADV_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= reg_wdata_i & ~(16'h8200);
      end
      if (reg_wr_i && (reg_addr_i == plm_pkg::ADDR_ADV)) begin
        adv_q <= {11'h000, reg_wdata_i[4:0]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_q   <= 1'b0;
      speed_q  <= plm_pkg::SPD_10;
      full_q   <= 1'b0;
      master_q <= 1'b0;
    end else if (go_link_an) begin
      link_q   <= 1'b1;
      speed_q  <= plm_pkg::plm_speed_t'(hcd_res[2:1]);
      full_q   <= hcd_res[0];
      master_q <= 1'b0;
    end else if (go_link_pd && (state_d == plm_pkg::ST_LINK)) begin
      link_q   <= 1'b1;
      speed_q  <= line_i.mlt3 ? plm_pkg::SPD_100 : plm_pkg::SPD_10;
      full_q   <= 1'b0;
      master_q <= 1'b0;
    end else if (ms_ok && (state_d == plm_pkg::ST_LINK)) begin
      link_q   <= 1'b1;
      speed_q  <= plm_pkg::SPD_1000;
      full_q   <= 1'b1;
      master_q <= (ms_res == plm_pkg::MS_MASTER);
    end else if ((state_q == plm_pkg::ST_FORCE) && (state_d == plm_pkg::ST_FORCE)) begin
      link_q   <= force_ok;
      speed_q  <= force_ok ? force_spd : plm_pkg::SPD_10;
      full_q   <= ctrl_q[plm_pkg::CTRL_DUPLEX];
      master_q <= 1'b0;
    end else if (state_d != plm_pkg::ST_LINK) begin
      link_q   <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lp_an_able_q <= 1'b0;
      pd_fault_q   <= 1'b0;
      ms_fault_q   <= 1'b0;
      an_done_q    <= 1'b0;
      lpa_q        <= 16'h0000;
    end else begin
      if (code_rx) begin
        lpa_q        <= lp_code_i;
        lp_an_able_q <= 1'b1;
      end else if (go_link_pd && (state_d == plm_pkg::ST_LINK)) begin
        lpa_q        <= line_i.mlt3 ? plm_pkg::LPA_100H : plm_pkg::LPA_10H;
        lp_an_able_q <= 1'b0;
      end
      if (pd_fault_ev) begin
        pd_fault_q <= 1'b1;
      end else if (stat_rd) begin
        pd_fault_q <= 1'b0;
      end
      if (ms_fault_ev) begin
        ms_fault_q <= 1'b1;
      end else if (stat_rd) begin
        ms_fault_q <= 1'b0;
      end
      if (state_d == plm_pkg::ST_IDLE) begin
        an_done_q <= 1'b0;
      end else if (state_d == plm_pkg::ST_LINK) begin
        an_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crs_q   <= 1'b0;
      col_q   <= 1'b0;
      txclk_q <= 1'b0;
    end else begin
      crs_q   <= link_q && (speed_q != plm_pkg::SPD_1000) &&
                 (full_q ? rx_active_i : (rx_active_i || tx_active_i));
      col_q   <= link_q && (speed_q != plm_pkg::SPD_1000) && !full_q &&
                 rx_active_i && tx_active_i;
      txclk_q <= link_q && (speed_q == plm_pkg::SPD_1000) && !master_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        plm_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
        plm_pkg::ADDR_STAT: rdata_q <= {7'h00, an_done_q, ms_fault_q, pd_fault_q,
                                        lp_an_able_q, master_q, full_q, speed_q, link_q};
        plm_pkg::ADDR_LPA:  rdata_q <= lpa_q;
        plm_pkg::ADDR_ADV:  rdata_q <= adv_q;
        default:            rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_o        = rdata_q;
  assign link_up_o          = link_q;
  assign speed_o            = speed_q;
  assign full_duplex_o      = full_q;
  assign master_o           = master_q;
  assign tx_recovered_clk_o = txclk_q;
  assign crs_o              = crs_q;
  assign col_o              = col_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_pd_hit;
    go_link_pd && (state_d == plm_pkg::ST_LINK);
  endsequence

  sequence s_restart;
    restart_req && !sw_rst && !pdn_reset_i;
  endsequence

  property p_pd_half;
    s_pd_hit |=> link_q && !full_q;
  endproperty
  a_pd_half: assert property (p_pd_half) else $error("Parallel link not half duplex.");

  property p_pd_lp_clear;
    s_pd_hit |=> !lp_an_able_q && (lpa_q != 16'h0000);
  endproperty
  a_pd_lp_clear: assert property (p_pd_lp_clear) else $error("Partner status wrong.");

  property p_pd_fault;
    pd_fault_ev |=> pd_fault_q;
  endproperty
  a_pd_fault: assert property (p_pd_fault) else $error("Detection fault not flagged.");

  property p_pd_no_gig;
    s_pd_hit |=> speed_q != plm_pkg::SPD_1000;
  endproperty
  a_pd_no_gig: assert property (p_pd_no_gig) else $error("Parallel link at gigabit.");

  property p_slave_clk;
    ms_ok && (ms_res == plm_pkg::MS_SLAVE) && !restart_req && !sw_rst && !pdn_reset_i
      |=> ##1 txclk_q;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("Slave not on recovered clock.");

  property p_ms_fault;
    ms_fault_ev && !restart_req && !sw_rst && !pdn_reset_i |=>
      (state_q == plm_pkg::ST_FAULT) && ms_fault_q && !link_q;
  endproperty
  a_ms_fault: assert property (p_ms_fault) else $error("Role fault mishandled.");

  property p_force_no_gig;
    (state_q == plm_pkg::ST_FORCE) && link_q |-> speed_q != plm_pkg::SPD_1000;
  endproperty
  a_force_no_gig: assert property (p_force_no_gig) else $error("Forced gigabit link.");

  property p_half_col;
    link_q && !full_q && (speed_q != plm_pkg::SPD_1000) && tx_active_i && rx_active_i
      |=> crs_q && col_q;
  endproperty
  a_half_col: assert property (p_half_col) else $error("Collision not flagged.");

  property p_full_crs;
    link_q && full_q && !rx_active_i |=> !crs_q && !col_q;
  endproperty
  a_full_crs: assert property (p_full_crs) else $error("Full duplex carrier wrong.");

  property p_gig_crs;
    link_q && (speed_q == plm_pkg::SPD_1000) |=> !crs_q;
  endproperty
  a_gig_crs: assert property (p_gig_crs) else $error("Gigabit carrier not low.");

  property p_restart_wait;
    s_restart |=> (state_q == plm_pkg::ST_IDLE)[*2];
  endproperty
  a_restart_wait: assert property (p_restart_wait) else $error("Restart did not wait.");

endmodule // plm_top

// ==== tb/plm_partner.sv ====
// Behavioural remote link partner: line indications, code words and role config.
// Assumes the bench picks the line behaviour on mode_i just after a clock edge.
`timescale 1ns/1ps

module plm_partner (
  input  wire logic                 clk_i,
  input  wire logic [2:0]           mode_i,
  input  wire logic [15:0]          code_i,
  input  wire plm_pkg::plm_ms_cfg_t ms_i,
  output plm_pkg::plm_line_t        line_o,
  output logic                      code_valid_o,
  output logic [15:0]               code_o,
  output plm_pkg::plm_ms_cfg_t      ms_o
);
  logic [15:0] junk_q = 16'hA5C3;

  // Outside a pulse burst the code lines carry a changing pattern.
  always @(posedge clk_i) begin
    junk_q <= {junk_q[14:0], junk_q[15] ^ junk_q[13]};
  end

  always_comb begin
    line_o.flp   = (mode_i == 3'h4);
    line_o.mlt3  = mode_i[1] & ~mode_i[2];
    line_o.nlp   = mode_i[0] & ~mode_i[2];
    line_o.lost  = (mode_i == 3'h0);
    code_valid_o = line_o.flp;
    code_o       = code_valid_o ? code_i : junk_q;
    ms_o         = code_valid_o ? ms_i : ~ms_i;
  end
endmodule // plm_partner

// ==== tb/plm_top_tb.sv ====
// Self-checking bench for the link-mode resolution block.
// Assumes a 100 ns clock and a short restart wait of 20 cycles.
`timescale 1ns/1ps

module plm_top_tb;
  logic                 clk_i = 1'b0;
  logic                 rst_n = 1'b0;
  logic [3:0]           addr = 4'h0;
  logic [15:0]          wdata = 16'h0000;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic [15:0]          rdata;
  plm_pkg::plm_line_t   line;
  logic                 cv;
  logic [15:0]          code;
  plm_pkg::plm_ms_cfg_t lp_ms;
  plm_pkg::plm_ms_cfg_t p_ms = '0;
  logic [15:0]          p_code = 16'h0010;
  logic [2:0]           mode = 3'h0;
  logic                 ms_man = 1'b0;
  logic                 mst = 1'b0;
  logic                 mport = 1'b0;
  logic                 tx = 1'b0;
  logic                 rx = 1'b0;
  logic                 pdn = 1'b0;
  logic                 an_pin = 1'b1;
  logic                 link, full, master, rclk, crs, col;
  plm_pkg::plm_speed_t  speed;
  logic [6:0]           ms_tab [6] = '{7'h02, 7'h11, 7'h09, 7'h42, 7'h69, 7'h00};
  logic [15:0]          d;
  int                   num_errors = 0;
  int                   n_tests = 0;

  always #50 clk_i = ~clk_i;

  plm_partner u_far (.clk_i(clk_i), .mode_i(mode), .code_i(p_code), .ms_i(p_ms),
    .line_o(line), .code_valid_o(cv), .code_o(code), .ms_o(lp_ms));

  plm_top #(.RESTART_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .line_i(line),
    .lp_code_valid_i(cv), .lp_code_i(code), .lp_ms_i(lp_ms), .local_seed_i(11'h005),
    .cfg_an_en_i(an_pin), .cfg_ms_manual_i(ms_man), .cfg_master_i(mst),
    .cfg_multiport_i(mport), .pdn_reset_i(pdn), .tx_active_i(tx), .rx_active_i(rx),
    .link_up_o(link), .speed_o(speed), .full_duplex_o(full), .master_o(master),
    .tx_recovered_clk_o(rclk), .crs_o(crs), .col_o(col));

  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_link(input logic exp);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_i);
      #1;
      if (link === exp) return;
    end
    num_errors++;
    $display("BAD %0t link wait timed out", $time);
    wrap_up();
  endtask

  task automatic drop();
    mode <= 3'h0;
    wait_link(1'b0);
  endtask

  task automatic up(input logic [2:0] m);
    mode <= m;
    wait_link(1'b1);
  endtask

  task automatic act(input logic t, input logic r, input logic ec, input logic el);
    @(posedge clk_i);
    tx <= t;
    rx <= r;
    repeat (2) @(posedge clk_i);
    #1;
    chk_bit(crs, ec, "carrier");
    chk_bit(col, el, "collision");
    tx <= 1'b0;
    rx <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n <= 1'b1;
    reg_rd(plm_pkg::ADDR_CTRL);
    chk_word(d, plm_pkg::CTRL_RST, "ctrl reset");
    reg_rd(plm_pkg::ADDR_ADV);
    chk_word(d, plm_pkg::ADV_RST, "adv reset");
    reg_wr(4'h6, 16'hFFFF);
    reg_rd(4'h6);
    chk_word(d, 16'h0000, "unmapped");
    reg_wr(plm_pkg::ADDR_CTRL, 16'h3100);
    up(3'h1);
    chk_word({14'h0, speed}, 16'h0000, "pd speed 10");
    chk_bit(full, 1'b0, "pd duplex");
    reg_rd(plm_pkg::ADDR_STAT);
    chk_word(d & 16'h003F, 16'h0001, "pd status");
    reg_rd(plm_pkg::ADDR_LPA);
    chk_word(d, plm_pkg::LPA_10H, "pd ability 10");
    act(1'b1, 1'b0, 1'b1, 1'b0);
    act(1'b1, 1'b1, 1'b1, 1'b1);
    drop();
    up(3'h2);
    chk_word({14'h0, speed}, 16'h0001, "pd speed 100");
    reg_rd(plm_pkg::ADDR_STAT);
    chk_word(d & 16'h002F, 16'h0003, "pd status 100");
    reg_rd(plm_pkg::ADDR_LPA);
    chk_word(d, plm_pkg::LPA_100H, "pd ability 100");
    drop();
    mode <= 3'h3;
    repeat (10) @(posedge clk_i);
    #1 chk_bit(link, 1'b0, "detect fault link");
    mode <= 3'h0;
    reg_rd(plm_pkg::ADDR_STAT);
    chk_bit(d[6], 1'b1, "detect fault set");
    reg_rd(plm_pkg::ADDR_STAT);
    chk_bit(d[6], 1'b0, "detect fault clear");
    for (int k = 0; k < 6; k++) begin
      {ms_man, mst, mport, p_ms.manual, p_ms.value, p_ms.multiport} <= ms_tab[k][6:1];
      p_ms.seed <= 11'h00A;
      up(3'h4);
      chk_word({14'h0, speed}, 16'h0002, "gigabit speed");
      chk_bit(master, ms_tab[k][0], "role");
      @(posedge clk_i);
      #1 chk_bit(rclk, ~ms_tab[k][0], "tx clock");
      act(1'b1, 1'b1, 1'b0, 1'b0);
      drop();
    end
    {ms_man, mst, mport} <= 3'h0;
    p_ms <= '{manual: 1'b0, value: 1'b0, multiport: 1'b1, seed: 11'h00A};
    reg_wr(plm_pkg::ADDR_CTRL, 16'h1003);
    up(3'h4);
    chk_bit(master, 1'b1, "sw manual role");
    drop();
    p_code <= 16'h0008;
    up(3'h4);
    chk_word({13'h0, speed, full}, 16'h0003, "an 100 full");
    act(1'b1, 1'b0, 1'b0, 1'b0);
    reg_rd(plm_pkg::ADDR_LPA);
    chk_word(d, 16'h0008, "an ability");
    drop();
    p_code <= 16'h0010;
    reg_wr(plm_pkg::ADDR_CTRL, 16'h1000);
    {ms_man, mst} <= 2'h3;
    p_ms <= '{manual: 1'b1, value: 1'b1, multiport: 1'b0, seed: 11'h00A};
    mode <= 3'h4;
    repeat (10) @(posedge clk_i);
    #1 chk_bit(link, 1'b0, "role fault link");
    reg_rd(plm_pkg::ADDR_STAT);
    chk_bit(d[7], 1'b1, "role fault bit");
    p_ms.value <= 1'b0;
    wait_link(1'b1);
    chk_bit(master, 1'b1, "retry role");
    drop();
    reg_wr(plm_pkg::ADDR_CTRL, 16'h2100);
    up(3'h2);
    chk_word({14'h0, speed}, 16'h0001, "forced 100");
    chk_bit(full, 1'b1, "forced full");
    act(1'b1, 1'b0, 1'b0, 1'b0);
    act(1'b0, 1'b1, 1'b1, 1'b0);
    act(1'b1, 1'b1, 1'b1, 1'b0);
    reg_wr(plm_pkg::ADDR_CTRL, 16'h0000);
    mode <= 3'h1;
    repeat (5) @(posedge clk_i);
    wait_link(1'b1);
    chk_word({13'h0, speed, full}, 16'h0000, "forced 10 half");
    act(1'b1, 1'b0, 1'b1, 1'b0);
    reg_wr(plm_pkg::ADDR_CTRL, 16'h0040);
    repeat (10) @(posedge clk_i);
    #1 chk_bit(link, 1'b0, "forced gigabit");
    mode <= 3'h1;
    reg_wr(plm_pkg::ADDR_CTRL, 16'h1000);
    wait_link(1'b1);
    reg_wr(plm_pkg::ADDR_CTRL, 16'h1200);
    repeat (15) @(posedge clk_i);
    #1 chk_bit(link, 1'b0, "restart wait");
    wait_link(1'b1);
    reg_rd(plm_pkg::ADDR_CTRL);
    chk_word(d, 16'h1000, "restart clears");
    pdn <= 1'b1;
    @(posedge clk_i);
    pdn <= 1'b0;
    #1 chk_bit(link, 1'b0, "power-down restart");
    wait_link(1'b1);
    an_pin <= 1'b0;
    mode   <= 3'h2;
    repeat (10) @(posedge clk_i);
    #1 chk_bit(link, 1'b0, "pin forced 10");
    wrap_up();
  end
endmodule // plm_top_tb
